// ---- hw/srro_pkg.sv ----
/*
  Shared constants and types of the stacked region readout block.
  Assumes a sensor of fixed full size and a 32-bit register bus.
*/
package srro_pkg;
  // Geometry
  localparam int          DIM_W         = 13;
  localparam int          SUM_W         = 16;
  localparam int          PIX_W         = 12;
  localparam int          N_REG         = 8;
  localparam int          IDX_W         = 3;
  localparam logic [12:0] SENSOR_W      = 13'h1400;
  localparam logic [15:0] SENSOR_H      = 16'h0f00;
  localparam logic [12:0] WIDTH_MIN     = 13'h0008;
  localparam logic [12:0] WIDTH_STEPM   = 13'h0007;
  // Reset values and region count limit
  localparam logic [12:0] WIDTH_RST     = 13'h1400;
  localparam logic [12:0] LINES_RST     = 13'h0001;
  localparam logic [12:0] OFFS_RST      = 13'h0000;
  localparam logic [3:0]  COUNT_RST     = 4'h1;
  localparam logic [3:0]  COUNT_MAX     = 4'h8;
  // Output modes
  localparam logic [1:0]  MODE_NORMAL   = 2'h0;
  localparam logic [1:0]  MODE_STACKED  = 2'h1;
  localparam logic [1:0]  MODE_TRIGSEQ  = 2'h2;
  // Register byte addresses
  localparam int          ADDR_W        = 5;
  localparam logic [4:0]  REG_CTRL      = 5'h00;
  localparam logic [4:0]  REG_COUNT     = 5'h04;
  localparam logic [4:0]  REG_SELECT    = 5'h08;
  localparam logic [4:0]  REG_WIDTH     = 5'h0c;
  localparam logic [4:0]  REG_LINES     = 5'h10;
  localparam logic [4:0]  REG_COLX      = 5'h14;
  localparam logic [4:0]  REG_ROWY      = 5'h18;
  localparam logic [4:0]  REG_STATUS    = 5'h1c;

  typedef struct packed {
    logic [PIX_W-1:0] pix;
    logic             eol;
    logic             eof;
  } srro_word_t;

  typedef struct packed {
    logic             fval;
    logic             lval;
    logic             dval;
    logic [PIX_W-1:0] data;
  } srro_video_t;
endpackage

// ---- hw/srro_sync2.sv ----
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level or clock from outside mclk's domain.
*/
`timescale 1ns/1ps
module srro_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ---- hw/srro_buf2.sv ----
/*
  Two-entry valid/ready buffer in the pixel path.
  Assumes both sides on mclk; out_ready may stall for any time.
*/
`timescale 1ns/1ps
module srro_buf2 import srro_pkg::*; (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Fill side
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire srro_word_t in_data,
  // Drain side
  output logic            out_valid,
  input  wire logic       out_ready,
  output srro_word_t      out_data
);
  srro_word_t ent_q [2];
  srro_word_t ent_d [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       pop;
  logic       push;

  always_comb begin
    pop      = out_ready && (cnt_q != 2'h0);
    push     = in_valid && (cnt_q != 2'h2);
    ent_d    = ent_q;
    cnt_d    = cnt_q;
    if (pop) begin
      ent_d[0] = ent_q[1];
    end
    if (push) begin
      ent_d[(pop ? cnt_q - 2'h1 : cnt_q) == 2'h0 ? 0 : 1] = in_data;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ent_q[0] <= '0;
      ent_q[1] <= '0;
      cnt_q    <= 2'h0;
    end else begin
      ent_q    <= ent_d;
      cnt_q    <= cnt_d;
    end
  end

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = ent_q[0];
endmodule

// ---- hw/srro_top.sv ----
/*
  Stacked region readout: region table, sensor read sequencer, video link output.
  Assumes a sensor read port with one cycle latency on mclk, a link clock and
  trigger arriving as pins, and an Avalon-MM master on mclk.
*/
`timescale 1ns/1ps
// What this block does
// (R01) Stacked mode reads up to eight bands per frame
// (R02) One common width for every band
// (R03) Region table used in stacked and trigger sequence modes, not in normal mode
// (R04) Region count one to eight, default one
// (R05) Selector picks entry for per-entry accesses
// (R06) Width default 5120, width plus offsets bounded
// (R07) Per-entry line count, default one
// (R08) Per-entry start column, default zero
// (R09) Per-entry start line; total lines below height
// (R10) Stacked frame is common width by summed lines
// (R11) Trigger sequence mode starts at first entry
// (R12) Entries ascending; bands start at their offsets
module srro_top import srro_pkg::*; (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               nrst,
  // Register bus
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // Trigger pin
  input  wire logic               trigger_in,
  // Sensor read port
  output logic                    sen_rd_req,
  output logic      [DIM_W-1:0]   sen_rd_line,
  output logic      [DIM_W-1:0]   sen_rd_col,
  input  wire logic [PIX_W-1:0]   sen_pix,
  // Video link
  input  wire logic               link_clk,
  output srro_video_t             lnk_out
);
  typedef enum logic {SRRO_IDLE, SRRO_RUN} srro_gen_t;

  // Unit steps sized to their counters
  localparam logic [DIM_W-1:0] D_ONE = DIM_W'(1);
  localparam logic [IDX_W-1:0] I_ONE = IDX_W'(1);

  function automatic logic [SUM_W-1:0] sum_lines(input logic [DIM_W-1:0] a [N_REG],
                                                 input logic [3:0] n);
    logic [SUM_W-1:0] s;
    s = '0;
    for (int i = 0; i < N_REG; i++) begin
      if (4'(i) < n) s = s + SUM_W'(a[i]);
    end
    return s;
  endfunction

  function automatic logic [DIM_W-1:0] max_col(input logic [DIM_W-1:0] a [N_REG]);
    logic [DIM_W-1:0] m;
    m = '0;
    for (int i = 0; i < N_REG; i++) begin
      if (a[i] > m) m = a[i];
    end
    return m;
  endfunction

  // Pin synchronisers and edge detection
  logic [1:0] pin_sy;
  logic [1:0] pin_prev_q;
  logic       lclk_fall;
  logic       trig_rise;

  srro_sync2 #(.W(2)) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({link_clk, trigger_in}),
    .sync_out (pin_sy)
  );

  always_ff @(posedge mclk) begin
    if (!nrst) pin_prev_q <= 2'h0;
    else       pin_prev_q <= pin_sy;
  end
  assign lclk_fall = pin_prev_q[1] && !pin_sy[1];
  assign trig_rise = !pin_prev_q[0] && pin_sy[0];

  // Configuration state
  logic [1:0]       mode_q,  mode_d;
  logic [3:0]       count_q, count_d;
  logic [IDX_W-1:0] sel_q,   sel_d;
  logic [DIM_W-1:0] width_q, width_d;
  logic [DIM_W-1:0] lines_q [N_REG];
  logic [DIM_W-1:0] lines_d [N_REG];
  logic [DIM_W-1:0] colx_q  [N_REG];
  logic [DIM_W-1:0] colx_d  [N_REG];
  logic [DIM_W-1:0] rowy_q  [N_REG];
  logic [DIM_W-1:0] rowy_d  [N_REG];
  logic             rej_q,   rej_d;
  logic             ack_q,   ack_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             mode_wr;
  logic             wr_fire;
  logic [DIM_W-1:0] wv;
  logic             wbig;
  logic [SUM_W-1:0] sum_all;

  // Generator state
  srro_gen_t        g_q, g_d;
  logic [1:0]       fmode_q, fmode_d;
  logic [IDX_W-1:0] e_q, e_d;
  logic [IDX_W-1:0] seq_q, seq_d;
  logic [DIM_W-1:0] l_q, l_d;
  logic [DIM_W-1:0] c_q, c_d;
  logic             req_q, req_d;
  logic             pend_q, pend_d;
  logic [1:0]       flag_q, flag_d;
  logic [DIM_W-1:0] rl_q, rl_d;
  logic [DIM_W-1:0] rc_q, rc_d;

  assign sum_all = sum_lines(lines_q, COUNT_MAX);
  assign wr_fire = avs_write && ack_q;
  assign wv      = avs_writedata[DIM_W-1:0];
  assign wbig    = |avs_writedata[31:DIM_W];

  // Bus answer one cycle after the request appears
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata    = rdata_q;

  always_comb begin
    ack_d   = (avs_read || avs_write) && !ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      case (avs_address)
        REG_CTRL:   rdata_d = {30'h0, mode_q};
        REG_COUNT:  rdata_d = {28'h0, count_q};
        REG_SELECT: rdata_d = {28'h0, {1'b0, sel_q} + 4'h1};
        REG_WIDTH:  rdata_d = {19'h0, width_q};
        REG_LINES:  rdata_d = {19'h0, lines_q[sel_q]};          // [R05]
        REG_COLX:   rdata_d = {19'h0, colx_q[sel_q]};
        REG_ROWY:   rdata_d = {19'h0, rowy_q[sel_q]};
        REG_STATUS: rdata_d = {sum_lines(lines_q, count_q), 8'h0, rej_q, seq_q, e_q,
                               g_q == SRRO_RUN};                 // [R10]
        default:    rdata_d = 32'h0;
      endcase
    end
  end

  always_comb begin
    mode_d  = mode_q;
    count_d = count_q;
    sel_d   = sel_q;
    width_d = width_q;
    lines_d = lines_q;
    colx_d  = colx_q;
    rowy_d  = rowy_q;
    rej_d   = rej_q;
    mode_wr = 1'b0;
    if (wr_fire) begin
      rej_d = 1'b0;
      case (avs_address)
        REG_CTRL: begin
          if (avs_writedata[31:2] == '0 && avs_writedata[1:0] <= MODE_TRIGSEQ) begin
            mode_d  = avs_writedata[1:0];
            mode_wr = 1'b1;
          end else rej_d = 1'b1;
        end
        REG_COUNT: begin
          if (!wbig && wv != '0 && wv <= DIM_W'(COUNT_MAX)) count_d = wv[3:0];  // [R04]
          else rej_d = 1'b1;
        end
        REG_SELECT: begin
          if (!wbig && wv != '0 && wv <= DIM_W'(COUNT_MAX)) sel_d = IDX_W'(wv - D_ONE);
          else rej_d = 1'b1;
        end
        REG_WIDTH: begin
          if (!wbig && wv >= WIDTH_MIN && (wv & WIDTH_STEPM) == '0
              && {1'b0, wv} + {1'b0, max_col(colx_q)} <= {1'b0, SENSOR_W}) begin
            width_d = wv;                                          // [R02] [R06]
          end else rej_d = 1'b1;
        end
        REG_LINES: begin
          if (!wbig && wv != '0
              && sum_all - SUM_W'(lines_q[sel_q]) + SUM_W'(wv) < SENSOR_H
              && SUM_W'(wv) + SUM_W'(rowy_q[sel_q]) <= SENSOR_H) begin
            lines_d[sel_q] = wv;                                   // [R07] [R09]
          end else rej_d = 1'b1;
        end
        REG_COLX: begin
          if (!wbig && {1'b0, wv} + {1'b0, width_q} <= {1'b0, SENSOR_W}) begin
            colx_d[sel_q] = wv;                                    // [R08] [R06]
          end else rej_d = 1'b1;
        end
        REG_ROWY: begin
          if (!wbig && SUM_W'(wv) + SUM_W'(lines_q[sel_q]) <= SENSOR_H) begin
            rowy_d[sel_q] = wv;                                    // [R09]
          end else rej_d = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
      mode_q  <= MODE_NORMAL;
      count_q <= COUNT_RST;
      sel_q   <= '0;
      width_q <= WIDTH_RST;
      rej_q   <= 1'b0;
      for (int i = 0; i < N_REG; i++) begin
        lines_q[i] <= LINES_RST;
        colx_q[i]  <= OFFS_RST;
        rowy_q[i]  <= OFFS_RST;
      end
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      mode_q  <= mode_d;
      count_q <= count_d;
      sel_q   <= sel_d;
      width_q <= width_d;
      rej_q   <= rej_d;
      lines_q <= lines_d;
      colx_q  <= colx_d;
      rowy_q  <= rowy_d;
    end
  end

  // Sensor read sequencer
  logic             buf_in_ready;
  logic             issue;
  logic [DIM_W-1:0] cur_w, cur_h, cur_r0, cur_c0;
  logic [IDX_W-1:0] last_e;
  logic             eol, eof;

  always_comb begin
    g_d     = g_q;
    fmode_d = fmode_q;
    e_d     = e_q;
    seq_d   = seq_q;
    l_d     = l_q;
    c_d     = c_q;
    rl_d    = rl_q;
    rc_d    = rc_q;
    flag_d  = flag_q;
    pend_d  = req_q;
    req_d   = 1'b0;
    cur_w   = (fmode_q == MODE_NORMAL) ? SENSOR_W : width_q;              // [R03]
    cur_h   = (fmode_q == MODE_NORMAL) ? SENSOR_H[DIM_W-1:0] : lines_q[e_q];
    cur_r0  = (fmode_q == MODE_NORMAL) ? '0 : rowy_q[e_q];
    cur_c0  = (fmode_q == MODE_NORMAL) ? '0 : colx_q[e_q];
    last_e  = (fmode_q == MODE_STACKED) ? IDX_W'(count_q - 4'h1) : e_q;   // [R01] [R12]
    eol     = (c_q == cur_w - D_ONE);
    eof     = eol && (l_q == cur_h - D_ONE) && (e_q == last_e);
    issue   = (g_q == SRRO_RUN) && buf_in_ready && !req_q && !pend_q;
    if (mode_wr) seq_d = '0;                                              // [R11]
    case (g_q)
      SRRO_IDLE: begin
        if (mode_q != MODE_TRIGSEQ || trig_rise) begin
          g_d     = SRRO_RUN;
          fmode_d = mode_q;
          e_d     = (mode_q == MODE_TRIGSEQ) ? seq_d : '0;                // [R11]
          l_d     = '0;
          c_d     = '0;
        end
      end
      SRRO_RUN: begin
        if (issue) begin
          req_d  = 1'b1;
          rl_d   = cur_r0 + l_q;                                          // [R12]
          rc_d   = cur_c0 + c_q;
          flag_d = {eol, eof};
          c_d    = eol ? '0 : c_q + D_ONE;
          if (eol) begin
            l_d = (l_q == cur_h - D_ONE) ? '0 : l_q + D_ONE;
            if (l_q == cur_h - D_ONE) begin
              if (e_q == last_e) begin
                g_d = SRRO_IDLE;
                if (fmode_q == MODE_TRIGSEQ && !mode_wr) begin
                  seq_d = (4'(seq_q) == count_q - 4'h1) ? '0 : seq_q + I_ONE;
                end
              end else e_d = e_q + I_ONE;                                 // [R12]
            end
          end
        end
      end
      default: g_d = SRRO_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      g_q     <= SRRO_IDLE;
      fmode_q <= MODE_NORMAL;
      e_q     <= '0;
      seq_q   <= '0;
      l_q     <= '0;
      c_q     <= '0;
      req_q   <= 1'b0;
      pend_q  <= 1'b0;
      flag_q  <= 2'h0;
      rl_q    <= '0;
      rc_q    <= '0;
    end else begin
      g_q     <= g_d;
      fmode_q <= fmode_d;
      e_q     <= e_d;
      seq_q   <= seq_d;
      l_q     <= l_d;
      c_q     <= c_d;
      req_q   <= req_d;
      pend_q  <= pend_d;
      flag_q  <= flag_d;
      rl_q    <= rl_d;
      rc_q    <= rc_d;
    end
  end

  assign sen_rd_req  = req_q;
  assign sen_rd_line = rl_q;
  assign sen_rd_col  = rc_q;

  // Flag pair follows the request into the buffer
  logic [1:0]  fl2_q;
  srro_word_t  buf_in, buf_out;
  logic        buf_out_valid, buf_out_ready;

  always_ff @(posedge mclk) begin
    if (!nrst) fl2_q <= 2'h0;
    else       fl2_q <= flag_q;
  end
  assign buf_in = '{pix: sen_pix, eol: fl2_q[1], eof: fl2_q[0]};

  srro_buf2 u_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (pend_q),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out)
  );

  // Link output, changes on link clock falling edges
  srro_video_t vid_q, vid_d;
  logic        gap_q, gap_d;
  logic        fend_q, fend_d;

  assign buf_out_ready = lclk_fall && !gap_q;

  always_comb begin
    vid_d  = vid_q;
    gap_d  = gap_q;
    fend_d = fend_q;
    if (lclk_fall) begin
      if (gap_q) begin
        vid_d.lval = 1'b0;
        vid_d.dval = 1'b0;
        gap_d      = 1'b0;
        if (fend_q) vid_d.fval = 1'b0;
        fend_d = 1'b0;
      end else if (buf_out_valid) begin
        vid_d  = '{fval: 1'b1, lval: 1'b1, dval: 1'b1, data: buf_out.pix};  // [R10]
        gap_d  = buf_out.eol;
        fend_d = buf_out.eof;
      end else begin
        vid_d.dval = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      vid_q  <= '0;
      gap_q  <= 1'b0;
      fend_q <= 1'b0;
    end else begin
      vid_q  <= vid_d;
      gap_q  <= gap_d;
      fend_q <= fend_d;
    end
  end
  assign lnk_out = vid_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_count_range;
    count_q >= COUNT_RST && count_q <= COUNT_MAX;
  endproperty
  a_count_range: assert property (p_count_range) else $error("region count out of range"); // [R04]

  property p_sel_only;
    wr_fire && avs_address == REG_LINES && !rej_d && sel_q != 3'h0
      |=> lines_q[sel_q] == $past(wv) && $stable(lines_q[0]);
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("line count write missed selected entry"); // [R05]

  property p_width_fit;
    {1'b0, width_q} + {1'b0, max_col(colx_q)} <= {1'b0, SENSOR_W};
  endproperty
  a_width_fit: assert property (p_width_fit) else $error("width plus offset exceeds sensor"); // [R06]

  property p_height_fit;
    sum_all < SENSOR_H;
  endproperty
  a_height_fit: assert property (p_height_fit) else $error("total lines reach sensor height"); // [R09]

  property p_normal_no_table;
    g_q == SRRO_RUN && fmode_q == MODE_NORMAL |-> e_q == '0 && cur_w == SENSOR_W;
  endproperty
  a_normal_no_table: assert property (p_normal_no_table) else $error("table used in normal mode"); // [R03]

  property p_ascending;
    g_q == SRRO_RUN && $changed(e_q) && $past(g_q) == SRRO_RUN |-> e_q == $past(e_q) + 3'h1;
  endproperty
  a_ascending: assert property (p_ascending) else $error("entries not ascending"); // [R12]

  property p_active_only;
    g_q == SRRO_RUN && fmode_q == MODE_STACKED |-> 4'(e_q) < count_q;
  endproperty
  a_active_only: assert property (p_active_only) else $error("entry above region count"); // [R01]

  property p_seq_restart;
    mode_wr && mode_d == MODE_TRIGSEQ |=> seq_q == '0;
  endproperty
  a_seq_restart: assert property (p_seq_restart) else $error("sequence not back at first entry"); // [R11]

  property p_frame_end;
    lclk_fall && !gap_q && buf_out_valid && buf_out.eof |=> ##[1:80] !vid_q.fval;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame valid did not fall"); // [R10]

  property p_reset_vals;
    $past(!nrst) |-> lines_q[7] == LINES_RST && colx_q[7] == OFFS_RST && width_q == WIDTH_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong table reset values"); // [R07] [R08]

  c_stacked_end: cover property (g_q == SRRO_RUN && fmode_q == MODE_STACKED && issue && eof);
  c_trig_start:  cover property (trig_rise && mode_q == MODE_TRIGSEQ && g_q == SRRO_IDLE);
  c_buf_full:    cover property (!buf_in_ready);
  c_bus_wait:    cover property (avs_waitrequest ##1 !avs_waitrequest && avs_read);
endmodule

// ---- sim/srro_grabber.sv ----
/*
  Behavioural frame grabber on the video link.
  Assumes it samples the link at link_clk rising edges, as a receiver does.
*/
`timescale 1ns/1ps
module srro_grabber import srro_pkg::*; (
  // Link side
  input  wire logic         link_clk,
  input  wire logic         nrst,
  input  wire srro_video_t  lnk_in,
  // Capture results
  output logic [15:0]       px_cnt,
  output logic [PIX_W-1:0]  last_pix,
  output logic              fault
);
  always @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      px_cnt <= 16'h0;
      last_pix <= '0;
      fault <= 1'b0;
    end else if (lnk_in.dval === 1'b1) begin
      // Pixel outside a line or frame
      if (lnk_in.lval !== 1'b1 || lnk_in.fval !== 1'b1) fault <= 1'b1;
      // A lost or doubled pixel breaks the column ramp
      if (px_cnt != 16'h0 && lnk_in.data[5:0] !== last_pix[5:0] + 6'h1) fault <= 1'b1;
      px_cnt <= px_cnt + 16'h1;
      last_pix <= lnk_in.data;
    end
  end
endmodule

// ---- sim/tb_srro_top.sv ----
/*
  Testbench of the stacked region readout: register rows, link stall, trigger, reset.
  Assumes the grabber model on the link and a behavioural sensor in here.
*/
`timescale 1ns/1ps
module tb_srro_top import srro_pkg::*; ();
  typedef struct packed {
    logic        w;
    logic [4:0]  wa;
    logic [31:0] wd;
    logic [4:0]  ra;
    logic [31:0] m;
    logic [31:0] e;
  } srro_row_t;
  localparam logic [31:0] M = 32'hffffffff;
  logic              mclk, nrst, link_clk, lnk_run, trig, rd, wr, wreq, sreq, fault;
  logic [4:0]        adr;
  logic [31:0]       wdat, rdat;
  logic [DIM_W-1:0]  sline, scol;
  logic [PIX_W-1:0]  spix, last_pix;
  logic [15:0]       px_cnt;
  srro_video_t       lnk;
  int                err_total = 0;
  int                comparisons = 0;
  int                req_n = 0;
  srro_row_t         rows [27] = '{
    '{1'b1, REG_COUNT,  32'h8,     REG_COUNT,  M, 32'h8},
    '{1'b1, REG_COUNT,  32'h0,     REG_COUNT,  M, 32'h8},
    '{1'b1, REG_COUNT,  32'h9,     REG_COUNT,  M, 32'h8},
    '{1'b1, REG_SELECT, 32'h3,     REG_SELECT, M, 32'h3},
    '{1'b1, REG_LINES,  32'ha,     REG_LINES,  M, 32'ha},
    '{1'b1, REG_SELECT, 32'h1,     REG_LINES,  M, 32'h1},
    '{1'b1, REG_WIDTH,  32'h13f0,  REG_WIDTH,  M, 32'h13f0},
    '{1'b1, REG_COLX,   32'h10,    REG_COLX,   M, 32'h10},
    '{1'b1, REG_WIDTH,  32'h13f8,  REG_WIDTH,  M, 32'h13f0},
    '{1'b1, REG_WIDTH,  32'hc,     REG_WIDTH,  M, 32'h13f0},
    '{1'b1, REG_SELECT, 32'h5,     REG_WIDTH,  M, 32'h13f0},
    '{1'b1, REG_LINES,  32'hee9,   REG_LINES,  M, 32'hee9},
    '{1'b1, REG_LINES,  32'hef0,   REG_LINES,  M, 32'hee9},
    '{1'b1, REG_ROWY,   32'h17,    REG_ROWY,   M, 32'h17},
    '{1'b1, REG_ROWY,   32'h18,    REG_ROWY,   M, 32'h17},
    '{1'b1, REG_COUNT,  32'h4,     REG_STATUS, 32'hffff0080, 32'hd0000},
    '{1'b1, REG_CTRL,   32'h3,     REG_CTRL,   M, 32'h0},
    '{1'b1, REG_CTRL,   32'h1,     REG_CTRL,   M, 32'h1},
    '{1'b1, REG_CTRL,   32'h2,     REG_STATUS, 32'h70, 32'h0},
    '{1'b1, REG_STATUS, M,         REG_STATUS, 32'hffff0000, 32'hd0000},
    '{1'b0, REG_CTRL,   32'h0,     REG_COUNT,  M, 32'h1},
    '{1'b0, REG_CTRL,   32'h0,     REG_SELECT, M, 32'h1},
    '{1'b0, REG_CTRL,   32'h0,     REG_WIDTH,  M, 32'h1400},
    '{1'b0, REG_CTRL,   32'h0,     REG_LINES,  M, 32'h1},
    '{1'b0, REG_CTRL,   32'h0,     REG_COLX,   M, 32'h0},
    '{1'b0, REG_CTRL,   32'h0,     REG_ROWY,   M, 32'h0},
    '{1'b0, REG_CTRL,   32'h0,     REG_CTRL,   M, 32'h0}};

  srro_top uut (.mclk(mclk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .trigger_in(trig), .sen_rd_req(sreq), .sen_rd_line(sline), .sen_rd_col(scol),
    .sen_pix(spix), .link_clk(link_clk), .lnk_out(lnk));
  srro_grabber gb (.link_clk(link_clk), .nrst(nrst), .lnk_in(lnk), .px_cnt(px_cnt),
    .last_pix(last_pix), .fault(fault));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Link clock, unrelated in phase to mclk, stoppable to stall the link
  initial begin
    link_clk = 1'b0;
    #17;
    forever begin
      #62.5;
      if (lnk_run) link_clk = ~link_clk;
    end
  end
  // Sensor: pixel is its address, garbage when not requested
  always @(posedge mclk) begin
    spix <= sreq ? {sline[5:0], scol[5:0]} : ~{sline[5:0], scol[5:0]};
    if (sreq === 1'b1) req_n <= req_n + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wr <= w;
    rd <= ~w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic run(input int lo, input int hi);
    logic [31:0] q;
    for (int i = lo; i <= hi; i++) begin
      if (rows[i].w) bus(1'b1, rows[i].wa, rows[i].wd, q);
      bus(1'b0, rows[i].ra, 32'h0, q);
      chk($sformatf("row %0d", i), rows[i].e, q & rows[i].m);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] q;
    logic [15:0] c;
    int          n0;
    nrst = 1'b0;
    lnk_run = 1'b1;
    trig = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdat = 32'h0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    run(0, 19);
    $display("register rows done");
    // Receiver stall: buffer fills, sensor reads stop, no pixel lost
    @(posedge mclk);
    lnk_run = 1'b0;
    repeat (100) @(posedge mclk);
    n0 = req_n;
    c = px_cnt - 16'h1;
    repeat (100) @(posedge mclk);
    chk("sensor requests", n0, req_n);
    chk("frame started", 32'h1, {31'h0, px_cnt != 16'h0});
    chk("pixel", {26'h0, c[5:0]}, {20'h0, last_pix});
    lnk_run = 1'b1;
    repeat (1500) @(posedge mclk);
    c = px_cnt - 16'h1;
    chk("pixel", {26'h0, c[5:0]}, {20'h0, last_pix});
    chk("link fault", 32'h0, {31'h0, fault});
    $display("link stall done");
    // Trigger during a running frame is ignored
    @(posedge mclk);
    trig <= 1'b1;
    repeat (10) @(posedge mclk);
    trig <= 1'b0;
    repeat (10) @(posedge mclk);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk("next entry", 32'h1, q & 32'h7f);
    $display("trigger done");
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    run(20, 26);
    $display("reset values done");
    tally_and_finish();
  end
endmodule
